// File: core/cpp_control_pins.sv
// control-pin power-down, self-test straps, shared interrupt pin and general io 0
`timescale 1ns/1ps
module cpp_control_pins
  import cpp_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  input  wire logic                   i_power_down_n_pin,
  input  wire logic                   i_self_test_enable_pin,
  input  wire logic                   i_pin4_in,
  input  wire logic [STRAP_ADC_W-1:0] i_config_strap_0,
  input  wire logic [STRAP_ADC_W-1:0] i_config_strap_1,
  input  wire logic                   i_pin4_sel_clk,
  input  wire logic                   i_pin4_pull_low_en,
  input  wire logic                   i_general_io_0_sel_audio,
  input  wire logic                   i_general_io_0_out_val,
  input  wire logic                   i_audio_serial_data_out,
  input  wire logic                   i_general_io_0_in,
  output      logic                   o_pin4_out,
  output      logic                   o_pin4_oe,
  output      logic                   o_general_io_0_out,
  output      logic                   o_general_io_0_oe,
  output      logic                   o_general_io_0_in,
  output      logic                   o_enabled,
  output      logic                   o_soft_reset,
  output      logic                   o_pll_run,
  output      logic                   o_outputs_oe,
  output      logic                   o_self_test_en,
  output      logic                   o_self_test_clk_int,
  output      logic                   o_interrupt_in,
  output      logic [STRAP_W-1:0]     o_config_0,
  output      logic [STRAP_W-1:0]     o_config_1,
  output      logic                   o_config_valid
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // analogue strap codes are assumed static while sampled; only single bits are synced
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
    end
    else
    begin
      meta_reg <= {i_general_io_0_in, i_pin4_in, i_self_test_enable_pin, i_power_down_n_pin};
      sync_reg <= meta_reg;
    end
  end

  logic pd_n_s;
  logic bist_en_s;
  logic pin4_s;
  assign pd_n_s    = sync_reg[0];
  assign bist_en_s = sync_reg[1];
  assign pin4_s    = sync_reg[2];

  // ------------------------------------------------------------
  // power sequencer
  // ------------------------------------------------------------
  cpp_state_t          state_reg;
  logic [SETTLE_W-1:0] cnt_reg;
  logic                running;
  logic                restart;

  assign running = (state_reg == CPP_RUN);
  // any cycle spent down holds the rest of the chip in reset, so release restarts defaults
  assign restart = (state_reg != CPP_RUN);

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg <= CPP_DOWN;
      cnt_reg   <= '0;
    end
    else if (!pd_n_s)
    begin
      state_reg <= CPP_DOWN;
      cnt_reg   <= '0;
    end
    else
    begin
      case (state_reg)
        CPP_DOWN:
        begin
          state_reg <= CPP_SETTLE;
          cnt_reg   <= '0;
        end
        CPP_SETTLE:
        begin
          if (cnt_reg == SETTLE_W'(SETTLE_CYC - 1))
            state_reg <= CPP_RUN;
          else
            cnt_reg <= cnt_reg + 1'b1;
        end
        CPP_RUN:
          state_reg <= CPP_RUN;
        default:
          state_reg <= CPP_DOWN;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_enabled    <= 1'b0;
      o_soft_reset <= 1'b1;
      o_pll_run    <= 1'b0;
      o_outputs_oe <= 1'b0;
    end
    else
    begin
      o_enabled    <= running;
      o_soft_reset <= restart;
      o_pll_run    <= pd_n_s;
      o_outputs_oe <= running;
    end
  end

  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  cpp_strap_if strap0 ();
  cpp_strap_if strap1 ();
  logic        take;

  // latch straps once, at the end of settling
  assign take = (state_reg == CPP_SETTLE) && (cnt_reg == SETTLE_W'(SETTLE_CYC - 1)) && pd_n_s;
  assign strap0.level  = i_config_strap_0;
  assign strap0.sample = take;
  assign strap1.level  = i_config_strap_1;
  assign strap1.sample = take;

  cpp_strap_decode u_dec0 (.i_clk(i_clk), .i_reset(i_reset || !pd_n_s), .strap(strap0));
  cpp_strap_decode u_dec1 (.i_clk(i_clk), .i_reset(i_reset || !pd_n_s), .strap(strap1));

  assign o_config_0     = strap0.setting;
  assign o_config_1     = strap1.setting;
  assign o_config_valid = o_enabled;

  // ------------------------------------------------------------
  // self-test and shared pin
  // ------------------------------------------------------------
  logic pin4_sel_reg;
  logic gio_sel_reg;
  logic gio_out_reg;

  // function selects return to defaults whenever the device restarts
  always_ff @(posedge i_clk)
  begin
    if (i_reset || restart)
    begin
      pin4_sel_reg  <= PIN4_SEL_RST;
      gio_sel_reg   <= GIO_SEL_RST;
      gio_out_reg   <= GIO_OUT_RST;
    end
    else
    begin
      pin4_sel_reg  <= i_pin4_sel_clk;
      gio_sel_reg   <= i_general_io_0_sel_audio;
      gio_out_reg   <= i_general_io_0_out_val;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset || restart)
    begin
      o_self_test_en      <= 1'b0;
      o_self_test_clk_int <= CPP_CLK_PIXEL;
      o_interrupt_in      <= 1'b0;
    end
    else
    begin
      o_self_test_en      <= bist_en_s;
      o_self_test_clk_int <= pin4_sel_reg ? pin4_s : CPP_CLK_PIXEL;
      o_interrupt_in      <= pin4_sel_reg ? 1'b0 : pin4_s;
    end
  end

  // pull-low while down is optional, so the chip-level enable decides it
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_pin4_out <= 1'b0;
      o_pin4_oe  <= 1'b0;
    end
    else
    begin
      o_pin4_out <= 1'b0;
      // waits for the sequencer to leave run, so the pin never pulls while still enabled
      o_pin4_oe  <= !pd_n_s && !running && i_pin4_pull_low_en;
    end
  end

  // ------------------------------------------------------------
  // general io 0
  // ------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_reset || restart)
    begin
      o_general_io_0_out <= GIO_OUT_RST;
      o_general_io_0_oe  <= 1'b0;
      o_general_io_0_in  <= 1'b0;
    end
    else
    begin
      o_general_io_0_out <= gio_sel_reg ? i_audio_serial_data_out : gio_out_reg;
      o_general_io_0_oe  <= 1'b1;
      o_general_io_0_in  <= sync_reg[3];
    end
  end

endmodule

// File: core/cpp_strap_decode.sv
// multi-level strap sampler and decoder
`timescale 1ns/1ps
module cpp_strap_decode
  import cpp_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  cpp_strap_if.dec  strap
);

  // ------------------------------------------------------------
  // level to setting
  // ------------------------------------------------------------
  // table not known: even bands of the divider ratio stand in for it
  function automatic logic [STRAP_W-1:0] band(input logic [STRAP_ADC_W-1:0] lvl);
    band = lvl[STRAP_ADC_W-1 -: STRAP_W];
  endfunction

  logic [STRAP_W-1:0] setting_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      setting_reg <= STRAP_RST_VAL;
    else if (strap.sample)
      setting_reg <= band(strap.level);
  end

  assign strap.setting = setting_reg;

endmodule

// File: pkg/cpp_pkg.sv
// constants and types for the control-pin power and self-test block
package cpp_pkg;

  // ------------------------------------------------------------
  // strap decode
  // ------------------------------------------------------------
  localparam int          STRAP_W        = 4;
  localparam int          STRAP_ADC_W    = 8;
  localparam logic [7:0]  STRAP_STEP     = 8'h10;
  localparam logic [3:0]  STRAP_RST_VAL  = 4'h0;

  // ------------------------------------------------------------
  // power-up sequencing
  // ------------------------------------------------------------
  // settle time after power-down release before straps are latched
  localparam int          SETTLE_NS      = 1000;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SETTLE_W       = 8;

  // ------------------------------------------------------------
  // reset values of pin function selections and the general io 0 output value
  // ------------------------------------------------------------
  localparam logic        PIN4_SEL_RST   = 1'b0;  // 0: interrupt input, 1: clock select
  localparam logic        GIO_SEL_RST    = 1'b0;  // 0: general io, 1: audio serial data
  localparam logic        GIO_OUT_RST    = 1'b0;

  typedef enum logic [1:0] {
    CPP_DOWN,
    CPP_SETTLE,
    CPP_RUN
  } cpp_state_t;

  typedef enum logic {
    CPP_CLK_PIXEL,
    CPP_CLK_INT33
  } cpp_bist_clk_t;

endpackage

// File: pkg/cpp_strap_if.sv
// strap sample and decoded settings between top and decoder
`timescale 1ns/1ps
interface cpp_strap_if;
  import cpp_pkg::*;
  logic [STRAP_ADC_W-1:0] level;
  logic                   sample;
  logic [STRAP_W-1:0]     setting;

  modport top (output level, output sample, input setting);
  modport dec (input level, input sample, output setting);
endinterface

// File: testbench/cpp_control_pins_props.sv
// assertion checker for the control-pin block
`timescale 1ns/1ps
module cpp_control_pins_props
  import cpp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_power_down_n_pin,
  input wire logic i_self_test_enable_pin,
  input wire logic i_pin4_in,
  input wire logic i_pin4_sel_clk,
  input wire logic i_general_io_0_sel_audio,
  input wire logic i_general_io_0_out_val,
  input wire logic o_pin4_out,
  input wire logic o_pin4_oe,
  input wire logic o_general_io_0_out,
  input wire logic o_general_io_0_oe,
  input wire logic o_enabled,
  input wire logic o_soft_reset,
  input wire logic o_outputs_oe,
  input wire logic o_config_valid,
  input wire logic o_self_test_en,
  input wire logic o_self_test_clk_int,
  input wire logic o_interrupt_in
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // edges the pin has been seen high; saturates so long runs stay high
  logic [7:0] hi_cnt_reg;
  always_ff @(posedge i_clk)
    if (i_reset || !i_power_down_n_pin)
      hi_cnt_reg <= 8'h00;
    else if (hi_cnt_reg != 8'hff)
      hi_cnt_reg <= hi_cnt_reg + 8'h01;
  property p_run_flags;
    (o_soft_reset != o_enabled) && (o_outputs_oe == o_enabled) && (o_config_valid == o_enabled);
  endproperty
  a_run_flags: assert property (p_run_flags) else $error("run flags disagree");
  property p_power_up;
    hi_cnt_reg >= SETTLE_CYC + 4 |-> o_enabled;
  endproperty
  a_power_up: assert property (p_power_up) else $error("not enabled after settle");
  // small gap above zero lets a power-down finish falling first
  property p_held_down;
    (hi_cnt_reg > 8'h04) && (hi_cnt_reg <= SETTLE_CYC) |-> !o_enabled;
  endproperty
  a_held_down: assert property (p_held_down) else $error("enabled too early");
  property p_drop;
    $fell(i_power_down_n_pin) |-> ##[1:4] !o_enabled;
  endproperty
  a_drop: assert property (p_drop) else $error("power-down not taken");
  property p_bist_on;
    (o_enabled && i_self_test_enable_pin) [*4] |-> o_self_test_en;
  endproperty
  a_bist_on: assert property (p_bist_on) else $error("self-test not on");
  property p_bist_off;
    (!i_self_test_enable_pin) [*4] |-> !o_self_test_en;
  endproperty
  a_bist_off: assert property (p_bist_off) else $error("self-test not off");
  property p_clk_sel;
    (o_enabled && i_pin4_sel_clk && i_pin4_in) [*5] |-> o_self_test_clk_int;
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("internal clock not picked");
  property p_int_in;
    (o_enabled && !i_pin4_sel_clk && i_pin4_in) [*5] |-> o_interrupt_in;
  endproperty
  a_int_in: assert property (p_int_in) else $error("interrupt input lost");
  property p_pull_low;
    o_pin4_oe |-> !o_enabled && !o_pin4_out;
  endproperty
  a_pull_low: assert property (p_pull_low) else $error("shared pin driven wrongly");
  property p_gpio;
    (o_enabled && !i_general_io_0_sel_audio && !i_general_io_0_out_val) [*3] |->
      o_general_io_0_oe && !o_general_io_0_out;
  endproperty
  a_gpio: assert property (p_gpio) else $error("general io 0 not low");
endmodule
bind cpp_control_pins cpp_control_pins_props cpp_control_pins_props_i (.*);

// File: testbench/cpp_control_pins_tb.sv
// self-checking bench for the control-pin block
`timescale 1ns/1ps
module cpp_control_pins_tb;
  import cpp_pkg::*;
  logic clk, rst, good, wake, st, p4, sel, pull, gsel, gval, aud, gin, pdn;
  logic o_p4, o_p4oe, o_go, o_goe, o_gin, en, srst, pll, ooe, sten, clki, intr, cv;
  logic [STRAP_ADC_W-1:0] s0, s1;
  logic [STRAP_W-1:0]     c0, c1;
  int                     failures = 0;
  int                     comparisons = 0;
  // st sel p4 gsel gval aud | sten clki intr gout
  logic [9:0] rows [4] = '{10'b111001_1100, 10'b010010_0001, 10'b001101_0011, 10'b100110_1000};
  cpp_host cpp_host_i (.i_supply_good(good), .i_wake(wake), .o_power_down_n_pin(pdn));
  cpp_control_pins cpp_control_pins_i (.i_clk(clk), .i_reset(rst), .i_power_down_n_pin(pdn),
    .i_self_test_enable_pin(st), .i_pin4_in(p4), .i_config_strap_0(s0), .i_config_strap_1(s1),
    .i_pin4_sel_clk(sel), .i_pin4_pull_low_en(pull), .i_general_io_0_sel_audio(gsel),
    .i_general_io_0_out_val(gval), .i_audio_serial_data_out(aud), .i_general_io_0_in(gin),
    .o_pin4_out(o_p4), .o_pin4_oe(o_p4oe), .o_general_io_0_out(o_go), .o_general_io_0_oe(o_goe),
    .o_general_io_0_in(o_gin), .o_enabled(en), .o_soft_reset(srst), .o_pll_run(pll),
    .o_outputs_oe(ooe), .o_self_test_en(sten), .o_self_test_clk_int(clki),
    .o_interrupt_in(intr), .o_config_0(c0), .o_config_1(c1), .o_config_valid(cv));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic results;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // whole run is about 450 cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    failures++;
    results;
  end
  initial
  begin
    {good, wake, st, p4, sel, pull, gsel, gval, aud, gin} = '0;
    s0 = 8'ha5;
    s1 = 8'h3c;
    rst = 1'b1;
    wait_cyc(6);
    check({en, srst, ooe, o_goe}, 8'h04);
    rst = 1'b0;
    pull = 1'b1;
    wait_cyc(4);
    check({o_p4oe, o_p4}, 8'h02);
    pull = 1'b0;
    wake = 1'b1;
    wait_cyc(200);
    check({en, ooe, o_goe, pll}, 8'h00);
    $display("held down done");
    good = 1'b1;
    wait_cyc(103);
    check(en, 8'h00);
    wait_cyc(1);
    check({en, srst, ooe, pll}, 8'h0b);
    check(cv, 8'h01);
    check({c0, c1}, 8'ha3);
    check({o_goe, o_go, o_p4oe}, 8'h04);
    $display("power-up done");
    foreach (rows[i])
    begin
      {st, sel, p4, gsel, gval, aud} = rows[i][9:4];
      wait_cyc(6);
      check({sten, intr, o_go}, {rows[i][3], rows[i][1:0]});
      if (sel)
        check(clki, rows[i][2]);
    end
    $display("pin table done");
    gin = 1'b1;
    wait_cyc(3);
    check(o_gin, 8'h01);
    wake = 1'b0;
    pull = 1'b1;
    s0 = 8'h1f;
    wait_cyc(5);
    check({en, ooe, o_goe, sten, pll, o_gin, o_p4oe}, 8'h01);
    wake = 1'b1;
    wait_cyc(104);
    check({en, c0}, 8'h11);
    $display("restart done");
    results;
  end
endmodule

// File: testbench/cpp_host.sv
// host model driving the power-down pin
`timescale 1ns/1ps
module cpp_host
(
  input  wire logic i_supply_good,
  input  wire logic i_wake,
  output      logic o_power_down_n_pin
);
  // released only once supplies are good and wake is set; an idle host drives it low through the AND
  assign o_power_down_n_pin = i_supply_good & i_wake;
endmodule
